// ==== pirqx_core_model.sv ====
`timescale 1ns/1ps
// ----
// core side: services one group line at a time
// ----
module pirqx_core_model
    import pirqx_pkg::*;
(
    input wire logic aclk,
    input wire logic vec_valid,
    input wire logic [31:0] vec_data,
    input wire logic [6:0] vec_src,
    output logic cpu_ack,
    output logic [3:0] cpu_ack_grp
);
    initial begin
        cpu_ack = 1'b0;
        cpu_ack_grp = 4'h0;
    end

    // one-cycle ack; the vector must land within the fetch budget or it counts as none
    task automatic service(input logic [3:0] g, output logic ok, output logic [6:0] s, output logic [31:0] d);
        ok = 1'b0;
        s = 7'h00;
        d = 32'h0;
        @(posedge aclk);
        cpu_ack <= 1'b1;
        cpu_ack_grp <= g;
        @(posedge aclk);
        cpu_ack <= 1'b0;
        cpu_ack_grp <= ~g; // released group code keeps moving so stale values never match
        for (int n = 0; n < VEC_MAX_CYC && !ok; n++) begin
            @(negedge aclk);
            if (vec_valid === 1'b1) begin
                ok = 1'b1;
                s = vec_src;
                d = vec_data;
            end
        end
    endtask
endmodule

// ==== pirqx_ext_ch.sv ====
`timescale 1ns/1ps
module pirqx_ext_ch
    import pirqx_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    pirqx_ext_if.ch xif
);

    logic pin_q_r;
    logic armed_r;
    logic [CNT_W-1:0] cnt_r;
    logic hit_r;
    logic rise;
    logic fall;
    logic edge_ok;

    // ----------------------------------------
    // edge qualification
    // ----------------------------------------
    assign rise = xif.pin & ~pin_q_r;
    assign fall = ~xif.pin & pin_q_r;
    // pol 1x = both edges, 01 rising, 00 falling
    assign edge_ok = armed_r & xif.en & (xif.pol[1] ? (rise | fall) : (xif.pol[0] ? rise : fall));

    // armed one cycle after reset so a pin already high is not an edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_q_r <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            pin_q_r <= xif.pin;
            armed_r <= 1'b1;
        end
    end

    // free-running stamp counter, wraps
    always_ff @(posedge aclk) begin
        if (!aresetn) cnt_r <= '0;
        else if (edge_ok) cnt_r <= '0;
        else cnt_r <= cnt_r + 16'h0001;
    end

    // one-cycle event pulse; masked channels stay silent
    always_ff @(posedge aclk) begin
        if (!aresetn) hit_r <= 1'b0;
        else hit_r <= edge_ok;
    end

    assign xif.cnt = cnt_r;
    assign xif.hit = hit_r;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_CNT_CLEAR: assert property (edge_ok |=> hit_r && cnt_r == 16'h0000)
        else $error("counter not cleared on edge");
    AST_CNT_RUN: assert property (!edge_ok && $past(aresetn) |=> cnt_r == $past(cnt_r) + 16'h0001)
        else $error("counter did not advance");
    AST_MASKED: assert property (!xif.en |=> !hit_r)
        else $error("masked channel fired");
    AST_RISE_ONLY: assert property (xif.pol == POL_RISE && fall |=> !hit_r)
        else $error("falling edge fired in rising mode");
    AST_FALL_HIT: assert property (armed_r && xif.en && xif.pol == POL_FALL && fall |=> hit_r)
        else $error("falling edge missed");

endmodule

// ==== pirqx_ext_if.sv ====
`timescale 1ns/1ps
interface pirqx_ext_if;
    logic pin;
    logic en;
    logic [1:0] pol;
    logic [15:0] cnt;
    logic hit;
    modport ch(input pin, input en, input pol, output cnt, output hit);
    modport top(output pin, output en, output pol, input cnt, input hit);
endinterface

// ==== pirqx_pkg.sv ====
// Overview of operation
// - up to 96 request inputs, tracked independently
// - twelve groups of eight, one line each
// - only 54 sources connected, rest inactive
// - per-source vector RAM, software writable anytime
// - vector supplied on service within 8 cycles
// - per-source enable gates group line request
// - fixed hardware priority plus core-side masking
// - three external channels, each with enable
// - falling, rising or both edge trigger
// - 16-bit up counter cleared on edge
// - channel input selected from gpio 0..31
package pirqx_pkg;

    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int NUM_SRC = 96;
    localparam int NUM_GRP = 12;
    localparam int GRP_SZ = 8;
    localparam int NUM_XCH = 3;
    localparam int CNT_W = 16;
    localparam int AW = 12;
    localparam int VEC_MAX_CYC = 8;
    localparam logic [95:0] SRC_USED = 96'h0000_0000_003f_ffff_ffff_ffff;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [11:0] OFF_ENA = 12'h000;
    localparam logic [11:0] OFF_PEND = 12'h040;
    localparam logic [11:0] GRP_SPAN = 12'h030;
    localparam logic [11:0] OFF_XCTL = 12'h080;
    localparam logic [11:0] OFF_XCNT = 12'h090;
    localparam logic [11:0] XCH_SPAN = 12'h00c;
    localparam logic [11:0] OFF_STAT = 12'h0a0;
    localparam logic [11:0] OFF_MASK = 12'h0a4;
    localparam logic [11:0] OFF_VEC = 12'h400;
    localparam logic [11:0] OFF_VEC_END = 12'h57c;

    // channel control fields and reset values
    localparam int XCTL_EN_BIT = 0;
    localparam int XCTL_POL_LSB = 1;
    localparam int XCTL_SEL_LSB = 8;
    localparam logic [31:0] XCTL_MASK = 32'h0000_1f07;
    localparam logic [31:0] XCTL_RST = 32'h0000_0000;
    localparam logic [7:0] ENA_RST = 8'h00;
    localparam logic [2:0] MASK_RST = 3'h0;
    localparam logic [1:0] POL_FALL = 2'h0;
    localparam logic [1:0] POL_RISE = 2'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    localparam logic [6:0] SPUR_SRC = 7'h7f;

    typedef enum logic [2:0] {K_ENA, K_PEND, K_XCTL, K_XCNT, K_STAT, K_MASK, K_VEC, K_NONE} pirqx_kind_t;

    // address to register kind
    function automatic pirqx_kind_t pirqx_decode(input logic [AW-1:0] a);
        pirqx_kind_t k;
        k = K_NONE;
        if (a[1:0] != 2'h0) k = K_NONE;
        else if (a < OFF_ENA + GRP_SPAN) k = K_ENA;
        else if (a >= OFF_PEND && a < OFF_PEND + GRP_SPAN) k = K_PEND;
        else if (a >= OFF_XCTL && a < OFF_XCTL + XCH_SPAN) k = K_XCTL;
        else if (a >= OFF_XCNT && a < OFF_XCNT + XCH_SPAN) k = K_XCNT;
        else if (a == OFF_STAT) k = K_STAT;
        else if (a == OFF_MASK) k = K_MASK;
        else if (a >= OFF_VEC && a <= OFF_VEC_END) k = K_VEC;
        return k;
    endfunction

    // word index within the register's own array
    function automatic logic [6:0] pirqx_index(input logic [AW-1:0] a, input pirqx_kind_t k);
        logic [11:0] b;
        b = 12'h000;
        case (k)
            K_PEND: b = OFF_PEND;
            K_XCTL: b = OFF_XCTL;
            K_XCNT: b = OFF_XCNT;
            K_VEC: b = OFF_VEC;
            default: b = OFF_ENA;
        endcase
        return 7'((a - b) >> 2);
    endfunction

    // byte-lane merge for write strobes
    function automatic logic [31:0] pirqx_merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
        end
        return r;
    endfunction

    // lowest set bit wins: {found, index}
    function automatic logic [3:0] pirqx_first(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) r = {1'b1, 3'(i)};
        end
        return r;
    endfunction

endpackage

// ==== pirqx_top.sv ====
`timescale 1ns/1ps
module pirqx_top
    import pirqx_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_SRC-1:0] periph_irq,
    input wire logic [31:0] gpio_in,
    input wire logic cpu_ack,
    input wire logic [3:0] cpu_ack_grp,
    output logic [NUM_GRP-1:0] cpu_irq_line,
    output logic vec_valid,
    output logic [31:0] vec_data,
    output logic [6:0] vec_src,
    output logic ext_irq_ch1,
    output logic ext_irq_ch2,
    output logic ext_irq_ch3,
    output logic irq
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic awready_r;
    logic wready_r;
    logic aw_ok_r;
    logic w_ok_r;
    logic [AW-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    logic [NUM_SRC-1:0] ena_r;
    logic [NUM_SRC-1:0] pend_r;
    logic [NUM_SRC-1:0] pend_nxt;
    logic [NUM_SRC-1:0] pe;
    logic [NUM_SRC-1:0] clr;
    logic [NUM_GRP-1:0] line_r;
    logic [31:0] vec_ram [NUM_SRC];
    logic [31:0] xctl_r [NUM_XCH];
    logic [2:0] stat_r;
    logic [2:0] stat_nxt;
    logic [2:0] mask_r;
    logic irq_r;

    logic fetch_v_r;
    logic fetch_hit_r;
    logic [6:0] fetch_src_r;
    logic vec_valid_r;
    logic [31:0] vec_data_r;
    logic [6:0] vec_src_r;

    logic wr_go;
    pirqx_kind_t wkind;
    pirqx_kind_t rkind;
    logic [6:0] widx;
    logic [6:0] ridx;
    logic ack_ok;
    logic [7:0] cand;
    logic [3:0] win;
    logic [2:0] ext_hit;
    logic [15:0] ext_cnt [NUM_XCH];

    // ----------------------------------------
    // axi4-lite write path
    // ----------------------------------------
    // address and data are taken in either order; one write in flight
    assign wr_go = aw_ok_r & w_ok_r & ~bvalid_r;
    assign wkind = pirqx_decode(aw_addr_r);
    assign widx = pirqx_index(aw_addr_r, wkind);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            aw_ok_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (s_axi_awvalid && awready_r) begin
            awready_r <= 1'b0;
            aw_ok_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else begin
            if (wr_go) aw_ok_r <= 1'b0;
            awready_r <= ~aw_ok_r & ~bvalid_r & ~wr_go;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_r <= 1'b0;
            w_ok_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= '0;
        end else if (s_axi_wvalid && wready_r) begin
            wready_r <= 1'b0;
            w_ok_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else begin
            if (wr_go) w_ok_r <= 1'b0;
            wready_r <= ~w_ok_r & ~bvalid_r & ~wr_go;
        end
    end

    // writes to read-only words are ignored but acknowledged
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= (wkind == K_NONE) ? RESP_DECERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // axi4-lite read path
    // ----------------------------------------
    assign rkind = pirqx_decode(s_axi_araddr);
    assign ridx = pirqx_index(s_axi_araddr, rkind);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= (rkind == K_NONE) ? RESP_DECERR : RESP_OKAY;
            unique case (rkind)
                K_ENA: rdata_r <= {24'h0, ena_r[ridx*8 +: 8]};
                K_PEND: rdata_r <= {24'h0, pend_r[ridx*8 +: 8]};
                K_XCTL: rdata_r <= xctl_r[ridx[1:0]];
                K_XCNT: rdata_r <= {16'h0, ext_cnt[ridx[1:0]]};
                K_STAT: rdata_r <= {29'h0, stat_r};
                K_MASK: rdata_r <= {29'h0, mask_r};
                K_VEC: rdata_r <= vec_ram[ridx];
                K_NONE: rdata_r <= 32'h0000_0000;
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end else begin
            arready_r <= ~rvalid_r;
        end
    end

    // ----------------------------------------
    // source enables and vector ram
    // ----------------------------------------
    // one byte per group, lane 0
    always_ff @(posedge aclk) begin
        if (!aresetn) ena_r <= {NUM_GRP{ENA_RST}};
        else if (wr_go && wkind == K_ENA && w_strb_r[0]) ena_r[widx*8 +: 8] <= w_data_r[7:0];
    end

    // no reset: software loads every vector before enabling a source
    always_ff @(posedge aclk) begin
        if (wr_go && wkind == K_VEC) vec_ram[widx] <= pirqx_merge(vec_ram[widx], w_data_r, w_strb_r);
    end

    // ----------------------------------------
    // pending, priority and group lines
    // ----------------------------------------
    assign pe = pend_r & ena_r;
    assign ack_ok = cpu_ack && cpu_ack_grp < 4'(NUM_GRP);

    // lowest-numbered enabled pending source in the acked group wins
    always_comb begin
        cand = 8'h00;
        clr = '0;
        if (ack_ok) cand = pe[cpu_ack_grp*8 +: 8];
        win = pirqx_first(cand);
        if (ack_ok && win[3]) clr[{cpu_ack_grp, win[2:0]}] = 1'b1;
    end

    // a new request in the ack cycle wins over the clear
    assign pend_nxt = (pend_r & ~clr) | (periph_irq & SRC_USED);

    always_ff @(posedge aclk) begin
        if (!aresetn) pend_r <= '0;
        else pend_r <= pend_nxt;
    end

    // one line per group of eight
    genvar g;
    generate
        for (g = 0; g < NUM_GRP; g++) begin : gen_grp
            always_ff @(posedge aclk) begin
                if (!aresetn) line_r[g] <= 1'b0;
                else line_r[g] <= |pe[g*GRP_SZ +: GRP_SZ];
            end

            AST_LINE_FOLLOWS: assert property (@(posedge aclk) disable iff (!aresetn)
                $past(aresetn) |-> line_r[g] == |$past(pe[g*GRP_SZ +: GRP_SZ]))
                else $error("group line does not follow enabled pending");
        end
    endgenerate

    // ----------------------------------------
    // vector fetch
    // ----------------------------------------
    // two cycles from ack to vector; an empty group answers zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fetch_v_r <= 1'b0;
            fetch_hit_r <= 1'b0;
            fetch_src_r <= '0;
        end else begin
            fetch_v_r <= ack_ok;
            fetch_hit_r <= win[3];
            fetch_src_r <= {cpu_ack_grp[3:0], win[2:0]};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vec_valid_r <= 1'b0;
            vec_data_r <= '0;
            vec_src_r <= '0;
        end else begin
            vec_valid_r <= fetch_v_r;
            vec_data_r <= fetch_hit_r ? vec_ram[fetch_src_r] : 32'h0000_0000;
            vec_src_r <= fetch_hit_r ? fetch_src_r : SPUR_SRC;
        end
    end

    // ----------------------------------------
    // external channels
    // ----------------------------------------
    genvar k;
    generate
        for (k = 0; k < NUM_XCH; k++) begin : gen_xch
            pirqx_ext_if xif();
            // any of the first 32 gpios can feed any channel
            assign xif.pin = gpio_in[xctl_r[k][XCTL_SEL_LSB +: 5]];
            assign xif.en = xctl_r[k][XCTL_EN_BIT];
            assign xif.pol = xctl_r[k][XCTL_POL_LSB +: 2];
            assign ext_hit[k] = xif.hit;
            assign ext_cnt[k] = xif.cnt;

            pirqx_ext_ch u_ch (
                .aclk(aclk),
                .aresetn(aresetn),
                .xif(xif)
            );

            always_ff @(posedge aclk) begin
                if (!aresetn) xctl_r[k] <= XCTL_RST;
                else if (wr_go && wkind == K_XCTL && widx[1:0] == 2'(k))
                    xctl_r[k] <= pirqx_merge(xctl_r[k], w_data_r, w_strb_r) & XCTL_MASK;
            end
        end
    endgenerate

    // ----------------------------------------
    // status, mask and interrupt output
    // ----------------------------------------
    // write one to clear; a same-cycle event keeps its bit
    always_comb begin
        stat_nxt = stat_r;
        if (wr_go && wkind == K_STAT && w_strb_r[0]) stat_nxt = stat_r & ~w_data_r[2:0];
        stat_nxt = stat_nxt | ext_hit;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_r <= '0;
            mask_r <= MASK_RST;
            irq_r <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            if (wr_go && wkind == K_MASK && w_strb_r[0]) mask_r <= w_data_r[2:0];
            irq_r <= |(stat_nxt & mask_r);
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign cpu_irq_line = line_r;
    assign vec_valid = vec_valid_r;
    assign vec_data = vec_data_r;
    assign vec_src = vec_src_r;
    assign ext_irq_ch1 = ext_hit[0];
    assign ext_irq_ch2 = ext_hit[1];
    assign ext_irq_ch3 = ext_hit[2];
    assign irq = irq_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_ack;
        ack_ok;
    endsequence

    sequence s_vec;
        vec_valid_r;
    endsequence

    AST_VEC_LATENCY: assert property (@(posedge aclk) disable iff (!aresetn) s_ack |-> ##[1:8] s_vec)
        else $error("vector not supplied in time");
    AST_UNUSED_QUIET: assert property (@(posedge aclk) disable iff (!aresetn) (pend_r & ~SRC_USED) == '0)
        else $error("unconnected source pending");
    AST_DISABLED_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(aresetn) && $past(ena_r[7:0]) == 8'h00 |-> !line_r[0])
        else $error("disabled group raised its line");
    AST_WIN_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn)
        ack_ok && win[3] && !periph_irq[{cpu_ack_grp, win[2:0]}] |=> !pend_r[fetch_src_r] ##1
        vec_src_r == $past(fetch_src_r))
        else $error("winning source not reported");
    AST_IRQ_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> irq_r == |($past(stat_nxt) & $past(mask_r)))
        else $error("irq does not follow masked status");

endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench
    import pirqx_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [AW-1:0] s_axi_awaddr = 12'h000;
    logic [AW-1:0] s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_rdata, vec_data, rd, vd;
    logic [31:0] gpio_in = 32'h0;
    logic [NUM_SRC-1:0] periph_irq = 96'h0;
    logic cpu_ack, vec_valid, ext_irq_ch1, ext_irq_ch2, ext_irq_ch3, irq, ok;
    logic [3:0] cpu_ack_grp;
    logic [NUM_GRP-1:0] cpu_irq_line;
    logic [6:0] vec_src, src;
    logic [4:0] xsel[3] = '{5'h00, 5'h11, 5'h1f};
    int vsrc[3] = '{3, 5, 53};
    int hits[3] = '{0, 0, 0};
    int bad_count = 0, samples_checked = 0;

    always #50 aclk = ~aclk;

    pirqx_top pirqx_top_inst (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .periph_irq, .gpio_in, .cpu_ack, .cpu_ack_grp, .cpu_irq_line, .vec_valid, .vec_data,
        .vec_src, .ext_irq_ch1, .ext_irq_ch2, .ext_irq_ch3, .irq
    );
    pirqx_core_model pirqx_core_model_inst (
        .aclk, .vec_valid, .vec_data, .vec_src, .cpu_ack, .cpu_ack_grp
    );

    // ----
    // helpers
    // ----
    // count channel pulses mid-cycle, where each one-cycle pulse has settled
    always @(negedge aclk) begin
        if (ext_irq_ch1 === 1'b1) hits[0]++;
        if (ext_irq_ch2 === 1'b1) hits[1]++;
        if (ext_irq_ch3 === 1'b1) hits[2]++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checked %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic stall();
        bad_count++;
        $display("[FAIL] %0t no answer", $time);
        close_out();
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // leading edge keeps two tasks from assigning a strobe in one time step
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        if (n == 64) stall();
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        if (n == 64) stall();
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic w(input logic [11:0] a, input logic [31:0] d);
        wr(a, d, rs);
        chk(32'(rs), 32'(RESP_OKAY), "write resp");
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string m);
        rdr(a, rd, rs);
        chk(rd, e, m);
    endtask

    task automatic svc(input logic [3:0] g, input logic eok, input logic [6:0] es, input logic [31:0] ed);
        pirqx_core_model_inst.service(g, ok, src, vd);
        chk(32'(ok), 32'(eok), "vector answer");
        chk(32'(src), 32'(es), "winner");
        chk(vd, ed, "vector");
    endtask

    // move one pin, then expect an event only if the polarity accepts it
    task automatic edge_chk(input int k, input logic [4:0] p, input logic v, input logic e);
        @(posedge aclk);
        gpio_in[p] <= v;
        tick(3);
        rdr(OFF_XCNT + 12'(4 * k), rd, rs);
        if (e) chk(32'(rd < 32'h40), 32'h1, "stamp cleared");
        rchk(OFF_STAT, 32'(e) << k, "channel event");
        chk(32'(irq), 32'(e), "irq level");
        w(OFF_STAT, 32'h7);
    endtask

    // ----
    // main sequence
    // ----
    initial begin
        #(100 * 60000);
        stall();
    end

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        tick(2);
        rchk(OFF_ENA, 32'h0, "enable reset");
        rchk(OFF_XCTL, XCTL_RST, "channel reset");
        rdr(12'h0fc, rd, rs);
        chk(32'(rs), 32'(RESP_DECERR), "unmapped");
        wr(12'h0fc, 32'h0, rs);
        chk(32'(rs), 32'(RESP_DECERR), "unmapped write");
        foreach (vsrc[i]) w(OFF_VEC + 12'(4 * vsrc[i]), 32'ha000 + vsrc[i]);
        rchk(OFF_VEC + 12'h0d4, 32'ha035, "vector readback");
        $display("test bus done");
        w(OFF_ENA, 32'h28);
        w(OFF_ENA + 12'h018, 32'hff);
        @(posedge aclk);
        periph_irq <= (96'h1 << 60) | (96'h1 << 54) | (96'h1 << 53) | 96'h38;
        @(posedge aclk);
        periph_irq <= 96'h0;
        tick(3);
        chk(32'(cpu_irq_line), 32'h041, "group lines");
        rchk(OFF_PEND, 32'h38, "pending g0");
        rchk(OFF_PEND + 12'h018, 32'h20, "pending g6");
        rchk(OFF_PEND + 12'h01c, 32'h0, "pending g7");
        svc(4'h0, 1'b1, 7'h03, 32'ha003);
        svc(4'h0, 1'b1, 7'h05, 32'ha005);
        tick(2);
        chk(32'(cpu_irq_line), 32'h040, "disabled source");
        svc(4'h6, 1'b1, 7'h35, 32'ha035);
        svc(4'h0, 1'b1, SPUR_SRC, 32'h0);
        svc(4'hc, 1'b0, 7'h00, 32'h0);
        chk(32'(cpu_irq_line), 32'h0, "lines idle");
        $display("test service done");
        w(OFF_MASK, 32'h7);
        foreach (xsel[k]) begin
            w(OFF_XCTL + 12'(4 * k), (32'(xsel[k]) << 8) | (32'(k) << 1) | 32'h1);
            edge_chk(k, xsel[k], 1'b1, k != 0);
            edge_chk(k, xsel[k], 1'b0, k != 1);
        end
        w(OFF_MASK, 32'h3);
        @(posedge aclk);
        gpio_in[31] <= 1'b1;
        tick(3);
        chk(32'(irq), 32'h0, "masked event");
        rchk(OFF_STAT, 32'h4, "masked status");
        w(OFF_MASK, 32'h7);
        tick(1);
        chk(32'(irq), 32'h1, "unmasked event");
        w(OFF_STAT, 32'h4);
        tick(1);
        chk(32'(irq), 32'h0, "status cleared");
        foreach (hits[k]) chk(32'(hits[k]), 32'(k == 2 ? 3 : 1), "pulse count");
        $display("test external done");
        close_out();
    end
endmodule
